// [design/eet_pkg.sv]
package eet_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned PROGRAM_CYCLE_TIME_NS = 5000000;
    localparam int unsigned PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned MEM_WORDS = 1024;
    localparam int unsigned PAGE_BYTES = 16;
    localparam logic [9:0] ADDR_RESET = 10'h000;

    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int unsigned DA_TYPE_MSB = 7;
    localparam int unsigned DA_TYPE_LSB = 4;
    localparam int unsigned DA_SEL_UPPER = 3;
    localparam int unsigned DA_SEL_LOWER = 2;
    localparam int unsigned DA_PAGE_HI = 2;
    localparam int unsigned DA_PAGE_LO = 1;
    localparam int unsigned DA_RW = 0;

    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;

    localparam int unsigned PIN_SCL = 0;
    localparam int unsigned PIN_SDA = 1;
    localparam int unsigned PIN_SEL_UPPER = 2;
    localparam int unsigned PIN_SEL_LOWER = 3;
    localparam int unsigned PIN_INHIBIT = 4;
    localparam logic [4:0] PIN_RESET = 5'h03;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_DEV_ADDR,
        ST_WORD_ADDR,
        ST_WRITE_DATA,
        ST_READ_DATA,
        ST_IGNORE,
        ST_PROGRAM
    } eet_state_e;

endpackage : eet_pkg

// [design/eet_target.sv]
`timescale 1ns/10ps
`default_nettype none
module eet_target #(
    parameter bit variant_8k = 1'b0,
    parameter int unsigned prog_cycles = eet_pkg::PROG_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic scl_link,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic chip_select_upper_pin,
    input wire logic chip_select_lower_pin,
    input wire logic write_inhibit,
    output logic standby,
    output logic program_busy
);

    eet_pkg::eet_state_e state_reg;
    logic [7:0] link_shift_reg;
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_match;
    logic active;
    logic [3:0] bit_cnt_reg;
    logic oe_n_reg;
    logic mack_reg;
    logic [7:0] tx_reg;
    logic [9:0] addr_reg;
    logic [9:0] addr_rd_next;
    logic [15:0] page_mask_reg;
    logic [7:0] page_buf [eet_pkg::PAGE_BYTES];
    logic [7:0] mem [eet_pkg::MEM_WORDS];
    logic [31:0] prog_cnt_reg;
    logic [3:0] prog_idx_reg;
    logic prog_done;
    logic standby_reg;
    logic busy_reg;

    // link side: sampled straight off the pin on the link clock
    always_ff @(posedge scl_link)
    begin
        link_shift_reg <= {link_shift_reg[6:0], sda_in};
    end

    // all pins pass two flops; straps too, they may move at power-up
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pin_meta_reg <= eet_pkg::PIN_RESET;
            pin_sync_reg <= eet_pkg::PIN_RESET;
            // idle-high history, so leaving reset never looks like an edge
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else if (ce)
        begin
            pin_meta_reg <= {write_inhibit, chip_select_lower_pin, chip_select_upper_pin,
                sda_in, scl_link};
            pin_sync_reg <= pin_meta_reg;
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_s = pin_sync_reg[eet_pkg::PIN_SCL];
    assign sda_s = pin_sync_reg[eet_pkg::PIN_SDA];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    // sda moving with scl held high is never data
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // byte stays still from the eighth rising edge until long after the fall
    assign addr_match = (link_shift_reg[eet_pkg::DA_TYPE_MSB:eet_pkg::DA_TYPE_LSB]
        == eet_pkg::DEV_TYPE_CODE)
        && (link_shift_reg[eet_pkg::DA_SEL_UPPER] == pin_sync_reg[eet_pkg::PIN_SEL_UPPER])
        && (variant_8k
        || link_shift_reg[eet_pkg::DA_SEL_LOWER] == pin_sync_reg[eet_pkg::PIN_SEL_LOWER]);

    assign active = (state_reg != eet_pkg::ST_STANDBY) && (state_reg != eet_pkg::ST_IGNORE);

    // reads roll over the whole array, unlike writes
    always_comb
    begin
        addr_rd_next = 10'(addr_reg + 10'h001);
        addr_rd_next[9] = addr_rd_next[9] & variant_8k;
    end

    assign prog_done = (prog_cnt_reg == 32'(prog_cycles - 1));

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= eet_pkg::ST_STANDBY;
            bit_cnt_reg <= 4'h0;
            oe_n_reg <= 1'b1;
            mack_reg <= 1'b0;
            tx_reg <= 8'hFF;
            addr_reg <= eet_pkg::ADDR_RESET;
            page_mask_reg <= 16'h0000;
        end
        else if (ce)
        begin
            if (state_reg == eet_pkg::ST_PROGRAM)
            begin
                // pins are deaf here, so polling simply goes unanswered
                oe_n_reg <= 1'b1;
                if (prog_done)
                begin
                    state_reg <= eet_pkg::ST_STANDBY;
                end
            end
            else if (start_det)
            begin
                // a start in any state but ST_PROGRAM drops the old transfer; this is also recovery
                state_reg <= eet_pkg::ST_DEV_ADDR;
                bit_cnt_reg <= 4'h0;
                oe_n_reg <= 1'b1;
                page_mask_reg <= 16'h0000;
            end
            else if (stop_det)
            begin
                bit_cnt_reg <= 4'h0;
                oe_n_reg <= 1'b1;
                if (state_reg == eet_pkg::ST_WRITE_DATA && page_mask_reg != 16'h0000
                    && !pin_sync_reg[eet_pkg::PIN_INHIBIT])
                begin
                    state_reg <= eet_pkg::ST_PROGRAM;
                end
                else
                begin
                    state_reg <= eet_pkg::ST_STANDBY;
                end
            end
            else if (scl_rise && active)
            begin
                if (bit_cnt_reg != eet_pkg::BIT_ACK)
                begin
                    bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                end
                if (state_reg == eet_pkg::ST_READ_DATA && bit_cnt_reg == eet_pkg::BIT_LAST_DATA)
                begin
                    mack_reg <= ~sda_s;
                end
            end
            else if (scl_fall && active)
            begin
                if (bit_cnt_reg == eet_pkg::BIT_LAST_DATA)
                begin
                    unique case (state_reg)
                        eet_pkg::ST_DEV_ADDR:
                        begin
                            if (addr_match)
                            begin
                                oe_n_reg <= 1'b0;
                                mack_reg <= link_shift_reg[eet_pkg::DA_RW];
                                if (variant_8k)
                                begin
                                    addr_reg[9:8] <= link_shift_reg[eet_pkg::DA_PAGE_HI:
                                        eet_pkg::DA_PAGE_LO];
                                end
                                else
                                begin
                                    addr_reg[9:8] <= {1'b0,
                                        link_shift_reg[eet_pkg::DA_PAGE_LO]};
                                end
                            end
                            else
                            begin
                                state_reg <= eet_pkg::ST_IGNORE;
                            end
                        end
                        eet_pkg::ST_WORD_ADDR:
                        begin
                            addr_reg[7:0] <= link_shift_reg;
                            oe_n_reg <= 1'b0;
                            state_reg <= eet_pkg::ST_WRITE_DATA;
                        end
                        eet_pkg::ST_WRITE_DATA:
                        begin
                            page_buf[addr_reg[3:0]] <= link_shift_reg;
                            page_mask_reg[addr_reg[3:0]] <= 1'b1;
                            addr_reg[3:0] <= 4'(addr_reg[3:0] + 4'h1);
                            oe_n_reg <= 1'b0;
                        end
                        default:
                        begin
                            // read: hand the ninth bit to the controller
                            oe_n_reg <= 1'b1;
                        end
                    endcase
                end
                else if (bit_cnt_reg == eet_pkg::BIT_ACK)
                begin
                    bit_cnt_reg <= 4'h0;
                    oe_n_reg <= 1'b1;
                    if (state_reg == eet_pkg::ST_DEV_ADDR)
                    begin
                        if (mack_reg)
                        begin
                            state_reg <= eet_pkg::ST_READ_DATA;
                            tx_reg <= mem[addr_reg];
                            oe_n_reg <= mem[addr_reg][7];
                        end
                        else
                        begin
                            state_reg <= eet_pkg::ST_WORD_ADDR;
                        end
                    end
                    else if (state_reg == eet_pkg::ST_READ_DATA)
                    begin
                        addr_reg <= addr_rd_next;
                        if (mack_reg)
                        begin
                            tx_reg <= mem[addr_rd_next];
                            oe_n_reg <= mem[addr_rd_next][7];
                        end
                        else
                        begin
                            state_reg <= eet_pkg::ST_IGNORE;
                        end
                    end
                end
                else if (state_reg == eet_pkg::ST_READ_DATA && bit_cnt_reg != 4'h0)
                begin
                    oe_n_reg <= tx_reg[6];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    // one page entry per cycle, so the cycle must last at least sixteen clocks
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prog_cnt_reg <= 32'h0000_0000;
            prog_idx_reg <= 4'h0;
        end
        else if (ce)
        begin
            prog_cnt_reg <= (state_reg == eet_pkg::ST_PROGRAM)
                ? 32'(prog_cnt_reg + 32'h1) : 32'h0000_0000;
            prog_idx_reg <= (state_reg == eet_pkg::ST_PROGRAM)
                ? 4'(prog_idx_reg + 4'h1) : 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && !reset && state_reg == eet_pkg::ST_PROGRAM && page_mask_reg[prog_idx_reg])
        begin
            mem[{addr_reg[9:4], prog_idx_reg}] <= page_buf[prog_idx_reg];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            standby_reg <= 1'b1;
            busy_reg <= 1'b0;
        end
        else if (ce)
        begin
            standby_reg <= ~active;
            busy_reg <= (state_reg == eet_pkg::ST_PROGRAM);
        end
    end

    // open drain: the data line only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_reg;
    assign standby = standby_reg;
    assign program_busy = busy_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset || !ce);

    a_start_enters_addr: assert property (
        start_det && state_reg != eet_pkg::ST_PROGRAM
        |=> state_reg == eet_pkg::ST_DEV_ADDR && bit_cnt_reg == 4'h0 && sda_oe_n)
        else $error("start not taken");

    a_read_stop_standby: assert property (
        stop_det && (state_reg == eet_pkg::ST_READ_DATA || state_reg == eet_pkg::ST_IGNORE)
        |=> state_reg == eet_pkg::ST_STANDBY ##1 standby)
        else $error("stop after read did not reach standby");

    a_ack_on_ninth: assert property (
        scl_fall && bit_cnt_reg == eet_pkg::BIT_LAST_DATA
        && (state_reg == eet_pkg::ST_WORD_ADDR || state_reg == eet_pkg::ST_WRITE_DATA)
        |=> !sda_oe_n && bit_cnt_reg == eet_pkg::BIT_LAST_DATA)
        else $error("received word not acknowledged");

    a_addr_mismatch: assert property (
        scl_fall && bit_cnt_reg == eet_pkg::BIT_LAST_DATA
        && state_reg == eet_pkg::ST_DEV_ADDR && !addr_match
        |=> state_reg == eet_pkg::ST_IGNORE && sda_oe_n ##1 standby)
        else $error("mismatched address not ignored");

    a_addr_match_ack: assert property (
        scl_fall && bit_cnt_reg == eet_pkg::BIT_LAST_DATA
        && state_reg == eet_pkg::ST_DEV_ADDR && addr_match
        |=> !sda_oe_n && state_reg == eet_pkg::ST_DEV_ADDR)
        else $error("matching address not acknowledged");

    a_prog_silent: assert property (
        state_reg == eet_pkg::ST_PROGRAM |=> sda_oe_n)
        else $error("line driven during program cycle");

    a_prog_length: assert property (
        state_reg == eet_pkg::ST_PROGRAM |-> prog_cnt_reg < 32'(prog_cycles)
        && ((prog_cnt_reg == 32'h0) == $rose(state_reg == eet_pkg::ST_PROGRAM)))
        else $error("program cycle count wrong");

    a_prog_ends: assert property (
        state_reg == eet_pkg::ST_PROGRAM && prog_done |=> state_reg == eet_pkg::ST_STANDBY)
        else $error("program cycle overran");

    a_page_wrap: assert property (
        scl_fall && bit_cnt_reg == eet_pkg::BIT_LAST_DATA
        && state_reg == eet_pkg::ST_WRITE_DATA
        |=> addr_reg[9:4] == $past(addr_reg[9:4])
        && addr_reg[3:0] == 4'($past(addr_reg[3:0]) + 4'h1))
        else $error("page address did not wrap in place");

    a_inhibit_no_prog: assert property (
        stop_det && pin_sync_reg[eet_pkg::PIN_INHIBIT] && state_reg != eet_pkg::ST_PROGRAM
        |=> state_reg != eet_pkg::ST_PROGRAM)
        else $error("inhibited write started programming");

    c_byte_write: cover property (
        stop_det && state_reg == eet_pkg::ST_WRITE_DATA ##1 state_reg == eet_pkg::ST_PROGRAM);
    c_read_continue: cover property (
        scl_fall && bit_cnt_reg == eet_pkg::BIT_ACK && state_reg == eet_pkg::ST_READ_DATA
        && mack_reg);
    c_mismatch: cover property (state_reg == eet_pkg::ST_IGNORE);
    c_page_wrap: cover property (
        state_reg == eet_pkg::ST_WRITE_DATA && page_mask_reg == 16'hFFFF && scl_fall
        && bit_cnt_reg == eet_pkg::BIT_LAST_DATA);

endmodule : eet_target
`default_nettype wire

// [tb/eet_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module eet_ctl_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    logic [9:0] res;
    event done_ev;
    // idle bus: both lines released high
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    // scl low 10 and high 10 cycles; device answer settles in 3
    task automatic bit_io(input logic b, output logic r);
        sda_rel <= b;
        hold(5);
        scl <= 1'b1;
        hold(5);
        r = sda;
        hold(5);
        scl <= 1'b0;
        hold(5);
    endtask : bit_io
    task automatic start();
        sda_rel <= 1'b1;
        hold(5);
        scl <= 1'b1;
        hold(10);
        sda_rel <= 1'b0;
        hold(10);
        scl <= 1'b0;
        hold(5);
    endtask : start
    task automatic stop();
        sda_rel <= 1'b0;
        hold(5);
        scl <= 1'b1;
        hold(10);
        sda_rel <= 1'b1;
        hold(20);
    endtask : stop
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        res = {9'h000, r};
        -> done_ev;
    endtask : send
    task automatic recv(input logic ack_n);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(ack_n, r);
        res = {2'b01, d};
        -> done_ev;
    endtask : recv
endmodule : eet_ctl_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int PROG = 400;
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic sel_hi = 1'b0;
    logic sel_lo = 1'b0;
    logic inhibit = 1'b0;
    logic sda_out;
    logic sda_oe_n;
    logic standby;
    logic program_busy;
    wire logic scl;
    wire logic sda_rel;
    wire logic sda_w;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    logic [9:0] exp_q[$];
    event flag_ev;
    logic [7:0] page[16];
    // pulled-up open-drain wire
    assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;
    always #25 clk = ~clk;
    eet_target #(.variant_8k(1'b0), .prog_cycles(PROG)) dut (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .scl_link(scl),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .chip_select_upper_pin(sel_hi),
        .chip_select_lower_pin(sel_lo),
        .write_inhibit(inhibit),
        .standby(standby),
        .program_busy(program_busy)
    );
    eet_ctl_model ctl (
        .clk(clk),
        .sda(sda_w),
        .scl(scl),
        .sda_rel(sda_rel)
    );
    task automatic print_verdict();
        if (exp_q.size() != 0)
            failures++;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic take(input logic [9:0] got);
        logic [9:0] e;
        check_count++;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3FF;
        if (got !== e)
        begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, e);
        end
    endtask : take
    always @(ctl.done_ev) take(ctl.res);
    always @(flag_ev) take({8'h80, standby, program_busy});
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failures++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end
    function automatic logic [7:0] da(input logic p, input logic rw);
        return {4'hA, sel_hi, sel_lo, p, rw};
    endfunction : da
    // a = 0 means the byte must be acknowledged
    task automatic wr(input logic [7:0] d, input logic a);
        exp_q.push_back({9'h000, a});
        ctl.send(d);
    endtask : wr
    task automatic rd(input logic [7:0] d, input logic last);
        exp_q.push_back({2'b01, d});
        ctl.recv(last);
    endtask : rd
    // sampled at the falling edge so the outputs have settled
    task automatic flags(input logic s, input logic b);
        exp_q.push_back({8'h80, s, b});
        @(negedge clk);
        -> flag_ev;
        @(posedge clk);
    endtask : flags
    task automatic seek(input logic p, input logic [7:0] a);
        ctl.start();
        wr(da(p, 1'b0), 1'b0);
        wr(a, 1'b0);
        ctl.start();
        wr(da(p, 1'b1), 1'b0);
    endtask : seek
    initial
    begin
        logic p3;
        logic [7:0] wa3;
        logic [7:0] d3;
        logic [7:0] wa;
        logic [7:0] d;
        logic r;
        void'($urandom(32'h5C4A));
        @(posedge clk);
        sel_hi <= 1'($urandom);
        sel_lo <= 1'($urandom);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        ctl.hold(4);
        flags(1'b1, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            ctl.start();
            wr(da(1'b0, 1'b0) ^ (8'h04 << i), 1'b1);
            ctl.stop();
            flags(1'b1, 1'b0);
        end
        $display("test address refusal done");
        p3 = 1'($urandom);
        wa3 = 8'($urandom);
        d3 = 8'($urandom);
        ctl.start();
        wr(da(p3, 1'b0), 1'b0);
        wr(wa3, 1'b0);
        wr(d3, 1'b0);
        ctl.stop();
        flags(1'b0, 1'b1);
        ctl.start();
        wr(da(p3, 1'b0), 1'b1);
        ctl.stop();
        ctl.hold(PROG);
        flags(1'b1, 1'b0);
        ctl.start();
        wr(da(p3, 1'b0), 1'b0);
        wr(wa3, 1'b0);
        seek(p3, wa3);
        rd(d3, 1'b1);
        ctl.stop();
        flags(1'b1, 1'b0);
        $display("test byte write done");
        wa = {wa3[7:4] ^ 4'h1, 4'hE};
        ctl.start();
        wr(da(p3, 1'b0), 1'b0);
        wr(wa, 1'b0);
        // 18 bytes from offset 14: the last two overwrite the first two
        for (int i = 0; i < 18; i++)
        begin
            d = 8'($urandom);
            page[(i + 14) % 16] = d;
            wr(d, 1'b0);
        end
        ctl.stop();
        ctl.hold(PROG);
        seek(p3, {wa[7:4], 4'h0});
        for (int i = 0; i < 16; i++)
            rd(page[i], i == 15);
        ctl.stop();
        $display("test page write done");
        inhibit <= 1'b1;
        ctl.hold(4);
        ctl.start();
        wr(da(p3, 1'b0), 1'b0);
        wr(wa3, 1'b0);
        wr(~d3, 1'b0);
        ctl.stop();
        flags(1'b1, 1'b0);
        inhibit <= 1'b0;
        $display("test write inhibit done");
        ctl.start();
        wr(da(p3, 1'b0), 1'b0);
        wr(wa3, 1'b0);
        for (int i = 0; i < 4; i++)
            ctl.bit_io(~d3[7 - i], r);
        // restart mid-byte, then the recovery sequence
        ctl.start();
        for (int i = 0; i < 9; i++)
            ctl.bit_io(1'b1, r);
        ctl.start();
        ctl.stop();
        flags(1'b1, 1'b0);
        seek(p3, wa3);
        rd(d3, 1'b1);
        ctl.stop();
        $display("test abandon and recovery done");
        ctl.hold(10);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
